// File: srtc_pkg.sv
// ============================================================
// Shared constants for the serial seconds counter
package srtc_pkg;

    // ============================================================
    // Command codes, all taken least significant bit first
    localparam logic [7:0] CMD_READ_ROM   = 8'h33;
    localparam logic [7:0] CMD_MATCH_ROM  = 8'h55;
    localparam logic [7:0] CMD_SEARCH_ROM = 8'hF0;
    localparam logic [7:0] CMD_SKIP_ROM   = 8'hCC;
    localparam logic [7:0] CMD_READ_CLK   = 8'h66;
    localparam logic [7:0] CMD_WRITE_CLK  = 8'h99;

    // ============================================================
    // Control byte layout and reset values
    localparam int          CTRL_OSC_LO    = 2;
    localparam int          CTRL_OSC_HI    = 3;
    localparam int          CTRL_USER_LSB  = 4;
    localparam logic [3:0]  USER_RESET     = 4'h0;
    localparam logic        OSC_RUN_RESET  = 1'b0;
    localparam logic [31:0] SECONDS_RESET  = 32'h0000_0000;

    // ============================================================
    // Sizes and time base
    localparam int ID_BITS         = 64;
    localparam int ID_CRC_SPAN     = 56;
    localparam int CLK_FRAME_BYTES = 5;
    localparam int FIFO_WORDS      = 8;
    localparam int XTAL_HZ         = 32768;
    // Crystal ticks in one second of the seconds counter
    localparam int TICKS_PER_SEC   = XTAL_HZ;

    // Reflected form of x^8 + x^5 + x^4 + 1
    localparam logic [7:0] CRC_POLY_REFL = 8'h8C;

    typedef enum {
        ST_IDLE, ST_ROM_CMD, ST_READ_ROM, ST_MATCH, ST_SEARCH,
        ST_FUNC_CMD, ST_READ_CLK, ST_WRITE_CLK, ST_WAIT
    } srtc_state_t;

    // One bit through the check register
    function automatic logic [7:0] srtc_crc_step(input logic [7:0] crc, input logic b);
        logic fb;
        fb = crc[0] ^ b;
        return (crc >> 1) ^ (fb ? CRC_POLY_REFL : 8'h00);
    endfunction

    // Check value over the first n bits, register cleared first
    function automatic logic [7:0] srtc_crc_bits(input logic [63:0] data, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 64; i++) begin
            if (i < n) c = srtc_crc_step(c, data[i]);
        end
        return c;
    endfunction

endpackage

// File: srtc_fifo.sv
`timescale 1ns/1ps
// ============================================================
// Small flip-flop FIFO for outgoing clock bytes
module srtc_fifo
    import srtc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_WORDS
) (
    // Clock and control
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic             flush,
    // Fill side
    input  wire logic             inValid,
    output      logic             inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output      logic             outValid,
    input  wire logic             outReady,
    output      logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    // Honest flags from the fill count, both held low during a flush
    assign inReady  = (cnt_reg != (AW+1)'(DEPTH)) && !flush;
    assign outValid = (cnt_reg != '0) && !flush;
    assign outData  = mem_reg[rd_reg];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // ============================================================
    // Next pointers, count and storage
    always_comb begin
        mem_next = mem_reg;
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        cnt_next = cnt_reg;
        if (flush) begin
            wr_next  = '0;
            rd_next  = '0;
            cnt_next = '0;
        end else begin
            if (push) begin
                mem_next[wr_reg] = inData;
                wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            if (push && !pop) cnt_next = cnt_reg + 1'b1;
            else if (pop && !push) cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else if (ce) begin
            mem_reg <= mem_next;
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

// File: srtc_seconds_counter.sv
`timescale 1ns/1ps
// ============================================================
// Serial seconds counter, slave side, bit-slot level
module srtc_seconds_counter
    import srtc_pkg::*;
#(
    parameter logic [7:0]  TYPE_CODE  = 8'h5A,          // Arbitrary value
    parameter logic [47:0] SERIAL_NUM = 48'h0000_1234_5678, // Arbitrary value
    parameter int          SEC_TICKS  = TICKS_PER_SEC
) (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // Serial bus at slot level
    input  wire logic        busReset,
    input  wire logic        slotStrobe,
    input  wire logic        dqIn,
    output      logic        dqOut,
    output      logic        dqOe,
    // Time base and status
    input  wire logic        oscTick,
    output      logic        oscEnable,
    output      logic [7:0]  ctrlByte,
    output      logic [31:0] seconds
);
    localparam int PW = $clog2(SEC_TICKS);
    // identity with its zero-seeded check byte on top
    localparam logic [55:0] ID_BODY = {SERIAL_NUM, TYPE_CODE};
    localparam logic [63:0] IDENT   = {srtc_crc_bits({8'h00, ID_BODY}, ID_CRC_SPAN), ID_BODY};

    srtc_state_t state_reg, state_next;
    logic [7:0]  shift_reg, shift_next;
    logic [6:0]  bitCnt_reg, bitCnt_next;
    logic [1:0]  searchPh_reg, searchPh_next;
    logic [2:0]  byteIdx_reg, byteIdx_next;
    logic [3:0]  user_reg, user_next;
    logic        oscRun_reg, oscRun_next;
    logic [31:0] snap_reg, snap_next;
    logic        pending_reg, pending_next;
    logic [31:0] seconds_reg, seconds_next;
    logic [PW-1:0] pre_reg, pre_next;
    logic [2:0]  loadIdx_reg, loadIdx_next;
    logic [7:0]  tx_reg, tx_next;
    logic [3:0]  txBits_reg, txBits_next;
    logic        dqOe_reg, dqOe_next;
    logic [7:0]  shIn, loadByte, fifoData;
    logic        idBit, txBit, fifoReady, fifoValid, fifoPop, inReadClk;

    // low bits hard zero; both oscillator bits mirror the run state
    assign ctrlByte  = {user_reg, oscRun_reg, oscRun_reg, 2'b00};
    assign oscEnable = oscRun_reg;
    assign seconds   = seconds_reg;
    assign dqOut     = 1'b0;            // Open drain: only ever pulls low
    assign dqOe      = dqOe_reg;
    // new bit enters at the top, so bytes arrive LSB first
    assign shIn      = {dqIn, shift_reg[7:1]};
    assign idBit     = IDENT[bitCnt_reg[5:0]];
    assign inReadClk = (state_reg == ST_READ_CLK);

    // ============================================================
    // Protocol: ROM layer then clock layer
    always_comb begin
        state_next    = state_reg;
        shift_next    = shift_reg;
        bitCnt_next   = bitCnt_reg;
        searchPh_next = searchPh_reg;
        byteIdx_next  = byteIdx_reg;
        user_next     = user_reg;
        oscRun_next   = oscRun_reg;
        snap_next     = snap_reg;
        pending_next  = pending_reg;
        if (busReset) begin
            state_next    = ST_ROM_CMD;
            shift_next    = 8'h00;
            bitCnt_next   = '0;
            searchPh_next = '0;
            byteIdx_next  = '0;
            pending_next  = 1'b0;
        end else if (slotStrobe) begin
            case (state_reg)
                ST_ROM_CMD: begin
                    shift_next  = shIn;
                    bitCnt_next = bitCnt_reg + 1'b1;
                    if (bitCnt_reg == 7'd7) begin
                        bitCnt_next = '0;
                        case (shIn)
                            CMD_READ_ROM:   state_next = ST_READ_ROM;
                            CMD_MATCH_ROM:  state_next = ST_MATCH;
                            CMD_SEARCH_ROM: state_next = ST_SEARCH;
                            CMD_SKIP_ROM:   state_next = ST_FUNC_CMD;
                            default:        state_next = ST_WAIT;
                        endcase
                    end
                end
                ST_READ_ROM: begin
                    bitCnt_next = bitCnt_reg + 1'b1;
                    if (bitCnt_reg == 7'd63) begin
                        bitCnt_next = '0;
                        state_next  = ST_FUNC_CMD;
                    end
                end
                ST_MATCH: begin
                    bitCnt_next = bitCnt_reg + 1'b1;
                    if (dqIn != idBit) state_next = ST_WAIT;
                    else if (bitCnt_reg == 7'd63) begin
                        bitCnt_next = '0;
                        state_next  = ST_FUNC_CMD;
                    end
                end
                ST_SEARCH: begin
                    // Bit, complement, then the master's choice
                    searchPh_next = searchPh_reg + 1'b1;
                    if (searchPh_reg == 2'd2) begin
                        searchPh_next = '0;
                        bitCnt_next   = bitCnt_reg + 1'b1;
                        if (dqIn != idBit) state_next = ST_WAIT;
                        else if (bitCnt_reg == 7'd63) begin
                            bitCnt_next = '0;
                            state_next  = ST_FUNC_CMD;
                        end
                    end
                end
                ST_FUNC_CMD: begin
                    // only reachable after a ROM command succeeded
                    shift_next  = shIn;
                    bitCnt_next = bitCnt_reg + 1'b1;
                    if (bitCnt_reg == 7'd7) begin
                        bitCnt_next = '0;
                        if (shIn == CMD_READ_CLK) begin
                            // snapshot on the final command bit
                            snap_next  = seconds_reg;
                            state_next = ST_READ_CLK;
                        end else if (shIn == CMD_WRITE_CLK) begin
                            state_next = ST_WRITE_CLK;
                        end else begin
                            state_next = ST_WAIT;
                        end
                    end
                end
                ST_WRITE_CLK: begin
                    shift_next  = shIn;
                    bitCnt_next = {4'h0, bitCnt_reg[2:0] + 3'd1};
                    if (bitCnt_reg[2:0] == 3'd7) begin
                        if (byteIdx_reg != 3'd5) byteIdx_next = byteIdx_reg + 1'b1;
                        // control byte first, then counter bytes LSB first
                        if (byteIdx_reg == 3'd0) begin
                            // bit 3 alone sets the run state
                            oscRun_next = shIn[CTRL_OSC_HI];
                            user_next   = shIn[7:CTRL_USER_LSB];
                        end else if (byteIdx_reg <= 3'd4) begin
                            snap_next[{byteIdx_reg[1:0] - 2'd1, 3'b000} +: 8] = shIn;
                            if (byteIdx_reg == 3'd4) pending_next = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // control state changes only through the serial protocol
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg    <= ST_IDLE;
            shift_reg    <= 8'h00;
            bitCnt_reg   <= '0;
            searchPh_reg <= '0;
            byteIdx_reg  <= '0;
            user_reg     <= USER_RESET;
            oscRun_reg   <= OSC_RUN_RESET;
            snap_reg     <= SECONDS_RESET;
            pending_reg  <= 1'b0;
        end else if (ce) begin
            state_reg    <= state_next;
            shift_reg    <= shift_next;
            bitCnt_reg   <= bitCnt_next;
            searchPh_reg <= searchPh_next;
            byteIdx_reg  <= byteIdx_next;
            user_reg     <= user_next;
            oscRun_reg   <= oscRun_next;
            snap_reg     <= snap_next;
            pending_reg  <= pending_next;
        end
    end

    // ============================================================
    // Time base: prescaler and seconds counter
    always_comb begin
        seconds_next = seconds_reg;
        pre_next     = pre_reg;
        if (busReset && pending_reg) begin
            // written time lands on the bus reset
            seconds_next = snap_reg;
            pre_next     = '0;
        // crystal ticks count only while running
        end else if (oscRun_reg && oscTick) begin
            if (pre_reg == PW'(SEC_TICKS - 1)) begin
                pre_next     = '0;
                // plus one per second; wraps naturally
                seconds_next = seconds_reg + 32'd1;
            end else begin
                pre_next = pre_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seconds_reg <= SECONDS_RESET;
            pre_reg     <= '0;
        end else if (ce) begin
            seconds_reg <= seconds_next;
            pre_reg     <= pre_next;
        end
    end

    // ============================================================
    // Read path: loader fills the FIFO with the five-byte frame
    always_comb begin
        case (loadIdx_reg)
            3'd0:    loadByte = ctrlByte;
            3'd1:    loadByte = snap_reg[7:0];
            3'd2:    loadByte = snap_reg[15:8];
            3'd3:    loadByte = snap_reg[23:16];
            default: loadByte = snap_reg[31:24];
        endcase
    end

    srtc_fifo #(.WIDTH(8), .DEPTH(FIFO_WORDS)) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .flush    (!inReadClk),
        .inValid  (inReadClk),
        .inReady  (fifoReady),
        .inData   (loadByte),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData)
    );

    // Pop only when the shifter is empty; the loader stalls on a full FIFO
    assign fifoPop = inReadClk && (txBits_reg == 4'd0);

    always_comb begin
        loadIdx_next = loadIdx_reg;
        tx_next      = tx_reg;
        txBits_next  = txBits_reg;
        if (!inReadClk || busReset) begin
            loadIdx_next = '0;
            txBits_next  = '0;
        end else begin
            // frame repeats until the next bus reset
            if (fifoReady) loadIdx_next = (loadIdx_reg == 3'(CLK_FRAME_BYTES - 1)) ? '0 : loadIdx_reg + 1'b1;
            if (fifoPop && fifoValid) begin
                tx_next     = fifoData;
                txBits_next = 4'd8;
            end else if (slotStrobe && txBits_reg != 4'd0) begin
                tx_next     = tx_reg >> 1;
                txBits_next = txBits_reg - 1'b1;
            end
        end
    end

    // Bit offered in the next read slot; a 1 leaves the line released
    always_comb begin
        case (state_reg)
            ST_READ_ROM: txBit = idBit;
            ST_SEARCH:   txBit = (searchPh_reg == 2'd0) ? idBit : (searchPh_reg == 2'd1) ? !idBit : 1'b1;
            ST_READ_CLK: txBit = (txBits_reg != 4'd0) ? tx_reg[0] : 1'b1;
            default:     txBit = 1'b1;
        endcase
        dqOe_next = !txBit && !busReset;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loadIdx_reg <= '0;
            tx_reg      <= 8'h00;
            txBits_reg  <= '0;
            dqOe_reg    <= 1'b0;
        end else if (ce) begin
            loadIdx_reg <= loadIdx_next;
            tx_reg      <= tx_next;
            txBits_reg  <= txBits_next;
            dqOe_reg    <= dqOe_next;
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst || !ce);

    sequence s_readCmdDone;
        slotStrobe && !busReset && state_reg == ST_FUNC_CMD && bitCnt_reg == 7'd7 && shIn == CMD_READ_CLK;
    endsequence
    sequence s_ctrlByteDone;
        slotStrobe && !busReset && state_reg == ST_WRITE_CLK && byteIdx_reg == 3'd0 && bitCnt_reg[2:0] == 3'd7;
    endsequence

    a_ident_check_zero: assert property (srtc_crc_bits(IDENT, ID_BITS) == 8'h00)
        else $error("identity check byte does not clear the register");
    a_ctrl_low_zero: assert property (ctrlByte[1:0] == 2'b00)
        else $error("control bits 0 and 1 not zero");
    a_osc_bits_pair: assert property (ctrlByte[CTRL_OSC_HI] == oscEnable && ctrlByte[CTRL_OSC_LO] == oscEnable)
        else $error("oscillator bits disagree with run state");
    a_osc_stop_hold: assert property (!oscEnable && !(busReset && pending_reg) |=> $stable(seconds))
        else $error("counter moved with oscillator stopped");
    a_sec_step_one: assert property ($changed(seconds) && !$past(busReset) |-> seconds == $past(seconds) + 32'd1)
        else $error("counter stepped by other than one");
    a_write_bit3_wins: assert property (s_ctrlByteDone |=> oscEnable == $past(shift_reg[4]))
        else $error("run state not taken from bit 3");
    a_read_snapshot: assert property (s_readCmdDone |=> state_reg == ST_READ_CLK && snap_reg == $past(seconds))
        else $error("snapshot not taken at read command");
    a_commit_on_reset: assert property (busReset && pending_reg |=> seconds == $past(snap_reg) && !pending_reg)
        else $error("written time not loaded on bus reset");
    a_rom_gate_first: assert property ($rose(state_reg == ST_FUNC_CMD) |-> $past(state_reg) inside {ST_ROM_CMD, ST_READ_ROM, ST_MATCH, ST_SEARCH})
        else $error("clock layer entered without a ROM command");
    a_match_miss_wait: assert property (slotStrobe && !busReset && state_reg == ST_MATCH && dqIn != idBit |=> state_reg == ST_WAIT)
        else $error("mismatched identity not rejected");
endmodule

// File: srtc_master_model.sv
`timescale 1ns/1ps
// ============================================================
// Bus master at slot level: resets, write slots and read slots
module srtc_master_model (
    // Clock
    input  wire logic clk,
    // Slot signals toward the device
    output      logic busReset,
    output      logic slotStrobe,
    output      logic dqIn,
    // Device open-drain pull
    input  wire logic dqOut,
    input  wire logic dqOe
);
    logic mBit = 1'b1;
    initial begin
        busReset   = 1'b0;
        slotStrobe = 1'b0;
    end
    // Wired-AND line; a released line reads high through the pull-up
    assign dqIn = mBit & (dqOe ? dqOut : 1'b1);

    // Reset pulse, then the spacing the device needs before a slot
    task automatic bus_reset();
        @(posedge clk);
        busReset <= 1'b1;
        @(posedge clk);
        busReset <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // One slot; bit held through the strobe edge, released afterwards
    task automatic slot(input logic b, output logic r);
        repeat (4) @(posedge clk);
        mBit       <= b;
        slotStrobe <= 1'b1;
        #1 r = dqIn;
        @(posedge clk);
        slotStrobe <= 1'b0;
        mBit       <= 1'b1;
    endtask

    task automatic wr_byte(input logic [7:0] v);
        logic r;
        for (int i = 0; i < 8; i++) slot(v[i], r);
    endtask

    task automatic rd_byte(output logic [7:0] v);
        for (int i = 0; i < 8; i++) slot(1'b1, v[i]);
    endtask
endmodule

// File: tb_serial_rtc_seconds_counter.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the serial seconds counter
module tb_serial_rtc_seconds_counter
    import srtc_pkg::*;
;
    localparam logic [7:0]  TYPE_C = 8'h3C;              // Arbitrary value
    localparam logic [47:0] SER_N  = 48'h0000_0A0B_0C0D; // Arbitrary value
    localparam int          TICKS  = 4;                  // Short second keeps the run brief
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        oscTick = 1'b0;
    logic        busReset, slotStrobe, dqIn, dqOut, dqOe, oscEnable;
    logic [7:0]  ctrlByte;
    logic [31:0] seconds;
    logic [63:0] idExp, rom, romN;
    logic        bitR;
    logic [39:0] frame;
    int          numErrors = 0;
    int          nTests = 0;
    int          cycles = 0;

    always #12.5 clk = ~clk;

    srtc_seconds_counter #(.TYPE_CODE(TYPE_C), .SERIAL_NUM(SER_N), .SEC_TICKS(TICKS)) i_dut (
        .clk(clk), .rst(rst), .ce(1'b1), .busReset(busReset), .slotStrobe(slotStrobe),
        .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe), .oscTick(oscTick), .oscEnable(oscEnable),
        .ctrlByte(ctrlByte), .seconds(seconds));
    srtc_master_model i_master (.clk(clk), .busReset(busReset), .slotStrobe(slotStrobe),
        .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));

    // Check register, reflected feedback of x^8+x^5+x^4+1
    function automatic logic [7:0] crc8(input logic [63:0] d, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
        return c;
    endfunction

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        nTests++;
        if (got !== exp) begin
            numErrors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finalReport();
        $display("Checks %0d, errors %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Crystal ticks; ends once the last tick has landed
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk) oscTick <= 1'b1;
            @(posedge clk) oscTick <= 1'b0;
        end
        @(posedge clk);
        #1;
    endtask

    task automatic rd_frame(output logic [39:0] f);
        for (int k = 0; k < 5; k++) i_master.rd_byte(f[8*k +: 8]);
    endtask

    // Whole run needs some 3500 cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            numErrors++;
            $display("Error at %0t: timeout", $time);
            finalReport();
        end
    end

    initial begin
        idExp = {crc8({8'h00, SER_N, TYPE_C}, 56), SER_N, TYPE_C};
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 chk({oscEnable, ctrlByte, seconds}, 64'h0);
        i_master.bus_reset();
        i_master.wr_byte(CMD_READ_ROM);
        for (int k = 0; k < 8; k++) i_master.rd_byte(rom[8*k +: 8]);
        chk(rom, idExp);
        chk(crc8(rom, 64), 64'h0);
        i_master.bus_reset();
        i_master.wr_byte(CMD_SKIP_ROM);
        i_master.wr_byte(CMD_WRITE_CLK);
        i_master.wr_byte(8'hAB);
        @(posedge clk);
        #1 chk({oscEnable, ctrlByte}, {1'b1, 8'hAC});
        for (int k = 0; k < 4; k++) i_master.wr_byte(8'hFF - ((k == 0) ? 8'h01 : 8'h00));
        chk(seconds, 64'h0);
        i_master.bus_reset();
        chk(seconds, 64'hFFFF_FFFE);
        ticks(TICKS - 1);
        chk(seconds, 64'hFFFF_FFFE);
        ticks(1);
        chk(seconds, 64'hFFFF_FFFF);
        ticks(TICKS);
        chk(seconds, 64'h0);
        // Counter runs during the read, the frame must not
        i_master.bus_reset();
        i_master.wr_byte(CMD_MATCH_ROM);
        for (int k = 0; k < 8; k++) i_master.wr_byte(idExp[8*k +: 8]);
        i_master.wr_byte(CMD_READ_CLK);
        fork
            ticks(TICKS);
            rd_frame(frame);
        join
        chk(frame, {32'h0, 8'hAC});
        chk(seconds, 64'h1);
        rd_frame(frame);
        chk(frame, {32'h0, 8'hAC});
        // Search walk: read bit, read complement, write the own bit back
        i_master.bus_reset();
        i_master.wr_byte(CMD_SEARCH_ROM);
        for (int k = 0; k < 64; k++) begin
            i_master.slot(1'b1, rom[k]);
            i_master.slot(1'b1, romN[k]);
            i_master.slot(idExp[k], bitR);
        end
        chk(rom, idExp);
        chk(romN, ~idExp);
        i_master.wr_byte(CMD_READ_CLK);
        rd_frame(frame);
        chk(frame, {32'h1, 8'hAC});
        // A single wrong identity bit locks the device out
        i_master.bus_reset();
        i_master.wr_byte(CMD_MATCH_ROM);
        for (int k = 0; k < 8; k++) i_master.wr_byte(idExp[8*k +: 8] ^ {7'h0, k == 0});
        i_master.wr_byte(CMD_READ_CLK);
        rd_frame(frame);
        chk(frame, 40'hFF_FFFF_FFFF);
        i_master.bus_reset();
        i_master.wr_byte(CMD_SKIP_ROM);
        i_master.wr_byte(CMD_WRITE_CLK);
        i_master.wr_byte(8'h50);
        i_master.bus_reset();
        ticks(2 * TICKS);
        chk({oscEnable, ctrlByte, seconds}, {1'b0, 8'h50, 32'h1});
        finalReport();
    end
endmodule
